// file: rtl/ecc_event_ctrl.sv
// Conditional event controller: start/stop selectors, two qualifiers, event state, outputs.
// Assumes synchronous sensor inputs in setpoint units and an APB master on pclk.
// Function
// - Qualifier setting zero means always active; charge-state zero still obeys disconnect
// - Charge-state codes 0-7: always, float, night, day, digital, combinations
// - Codes 0-7: disconnect request forces charge-state qualifier inactive
// - Codes 8-15 repeat 0-7 without disconnect override
// - Threshold codes 1-8 compare temperature, battery, external, time
// - External voltage from sense terminal when selector is 2, else bus
// - Inactive event starts only when start and both qualifiers active
// - Active event ends on stop or either qualifier going inactive
// - Event indication; first bit shows start when off, stop when on
// - Second status bit is charge-state qualifier result
// - Third status bit is threshold result, one when disabled
// - Load source 4 drives load switch from event state
// - Stop code 14 ends event after run time from each start
// - A held start condition fires once, selector 0 excepted; blocked until it falls
// - Stop already active at start blocks the start
// - Start 0 always; 14/15 repeat at minutes or tenths of hours
// - Stop time below start time means next day
`timescale 1ns/1ps
`default_nettype none
module ecc_event_ctrl #(
  parameter logic [31:0] MINUTE_CYCLES = ecc_pkg::MINUTE_CYC,
  parameter int VW = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurements
  input wire logic [VW-1:0] time_of_day,
  input wire logic [VW-1:0] panel_voltage,
  input wire logic [VW-1:0] battery_voltage,
  input wire logic [VW-1:0] sense_voltage,
  input wire logic [VW-1:0] bus_voltage,
  input wire logic [VW-1:0] temperature,
  // Status inputs
  input wire logic float_state,
  input wire logic is_night,
  input wire logic push_button_input,
  input wire logic bus_digital_input,
  input wire logic low_battery_disconnect,
  // Outputs
  output logic event_active,
  output logic [2:0] status_bits,
  output logic load_switch,
  output logic relay_switch
);
  logic [31:0] start_q, start_d, stop_q, stop_d, qual_q, qual_d, setp_q, setp_d;
  logic ev_q, ev_d, blk_q, blk_d, prev_q, prev_d;
  logic [31:0] tick_q, tick_d;
  logic [10:0] rate_q, rate_d, run_q, run_d;
  logic [3:0] start_selector, stop_selector, charge_state_qualifier, threshold_qualifier;
  logic [1:0] sense_input_selector;
  logic [3:0] load_output_source, relay_output_source;
  logic [VW-1:0] external_voltage, start_set, stop_set, thr_set;
  logic start_c, stop_c, csq, thq, fire, min_tick, run_done, rate_due;
  logic [7:0] rate_lim, run_lim;

  // Signed-free compare helper, shared by the start/stop selectors and the threshold qualifier
  function automatic logic cmp(input logic [VW-1:0] a, input logic [VW-1:0] b,
                               input logic above);
    cmp = above ? (a > b) : (a < b);
  endfunction

  // Limit in minutes; eleven bits hold the 25.5 h top end of the hour codes
  function automatic logic [10:0] lim_min(input logic [3:0] sel, input logic [7:0] v);
    lim_min = (sel == ecc_pkg::SEL_RATE_MIN) ? {3'h0, v} :
              11'({3'h0, v} * 11'(ecc_pkg::TENTH_HOUR_MIN));
  endfunction

  // Common code 1-13 decode for start and stop selectors
  function automatic logic cond(input logic [3:0] sel, input logic [VW-1:0] sp);
    case (sel)
      4'h1: cond = cmp(time_of_day, sp, 1'b1);
      4'h2: cond = cmp(panel_voltage, sp, 1'b1);
      4'h3: cond = cmp(panel_voltage, sp, 1'b0);
      4'h4: cond = cmp(external_voltage, sp, 1'b1);
      4'h5: cond = cmp(external_voltage, sp, 1'b0);
      4'h6: cond = push_button_input && cmp(time_of_day, sp, 1'b1);
      4'h7: cond = !push_button_input && cmp(time_of_day, sp, 1'b1);
      4'h8, 4'h9, 4'ha, 4'hb: cond = cmp(time_of_day, sp, 1'b1);
      4'hc: cond = cmp(battery_voltage, sp, 1'b1);
      4'hd: cond = cmp(battery_voltage, sp, 1'b0);
      default: cond = 1'b0;
    endcase
  endfunction

  assign start_selector = start_q[ecc_pkg::SEL_LSB +: 4];
  assign stop_selector = stop_q[ecc_pkg::SEL_LSB +: 4];
  assign start_set = start_q[ecc_pkg::SET_LSB +: VW];
  assign stop_set = stop_q[ecc_pkg::SET_LSB +: VW];
  assign thr_set = setp_q[VW-1:0];
  assign charge_state_qualifier = qual_q[ecc_pkg::CSQ_LSB +: 4];
  assign threshold_qualifier = qual_q[ecc_pkg::THQ_LSB +: 4];
  assign sense_input_selector = qual_q[ecc_pkg::SNS_LSB +: 2];
  assign load_output_source = qual_q[ecc_pkg::LOAD_LSB +: 4];
  assign relay_output_source = qual_q[ecc_pkg::RELAY_LSB +: 4];
  assign rate_lim = start_q[ecc_pkg::SET_LSB +: 8];
  assign run_lim = stop_q[ecc_pkg::SET_LSB +: 8];

  // Sense terminal or bus accessory reading
  assign external_voltage = (sense_input_selector == ecc_pkg::SENSE_TERMINAL) ?
                            sense_voltage : bus_voltage;

  // Charge-state qualifier; low three bits choose, top bit skips the override
  always_comb
  begin
    case (charge_state_qualifier[2:0])
      3'h0: csq = 1'b1;
      3'h1: csq = float_state;
      3'h2: csq = is_night;
      3'h3: csq = !is_night;
      3'h4: csq = bus_digital_input;
      3'h5: csq = float_state && is_night;
      3'h6: csq = float_state && !is_night;
      default: csq = float_state && bus_digital_input;
    endcase
    if (charge_state_qualifier < ecc_pkg::CSQ_NO_LBD && low_battery_disconnect)
      csq = 1'b0;
  end

  // Threshold qualifier; codes above 8 are treated as always active
  always_comb
  begin
    case (threshold_qualifier)
      4'h1: thq = cmp(temperature, thr_set, 1'b1);
      4'h2: thq = cmp(temperature, thr_set, 1'b0);
      4'h3: thq = cmp(battery_voltage, thr_set, 1'b1);
      4'h4: thq = cmp(battery_voltage, thr_set, 1'b0);
      4'h5: thq = cmp(external_voltage, thr_set, 1'b1);
      4'h6: thq = cmp(external_voltage, thr_set, 1'b0);
      4'h7: thq = cmp(time_of_day, thr_set, 1'b1);
      4'h8: thq = cmp(time_of_day, thr_set, 1'b0);
      default: thq = 1'b1;
    endcase
  end

  // Minute ticker and repeat/run counters, counted in minutes against limits in minutes or 0.1 h units
  assign min_tick = (tick_q == MINUTE_CYCLES - 32'h0000_0001);
  assign rate_due = (rate_q >= lim_min(start_selector, rate_lim));
  assign run_done = (run_q >= lim_min(stop_selector, run_lim));

  always_comb
  begin
    // Start condition
    if (start_selector == ecc_pkg::SEL_ALWAYS)
      start_c = 1'b1;
    else if (start_selector >= ecc_pkg::SEL_RATE_MIN)
      start_c = rate_due;
    else
      start_c = cond(start_selector, start_set);
    // Stop condition; a stop time earlier than start time lies on the next day
    if (stop_selector == ecc_pkg::SEL_ALWAYS)
      stop_c = 1'b0;
    else if (stop_selector >= ecc_pkg::SEL_RATE_MIN)
      stop_c = ev_q && run_done;
    else if (stop_selector == 4'h1 && start_selector == 4'h1 && stop_set < start_set)
      stop_c = (time_of_day > stop_set) && (time_of_day < start_set);
    else
      stop_c = cond(stop_selector, stop_set);
  end

  // Event state machine; a held start fires once, selector 0 never locks itself out
  // A start may still fire later when a qualifier comes up, stop only blocks at the edge
  always_comb
  begin
    fire = start_c && (!blk_q || start_selector == ecc_pkg::SEL_ALWAYS) &&
           csq && thq && !stop_c;
    ev_d = ev_q;
    blk_d = blk_q;
    if (!start_c)
      blk_d = 1'b0;
    else if (fire || (!prev_q && stop_c))
      blk_d = 1'b1;
    if (!ev_q && fire)
      ev_d = 1'b1;
    else if (ev_q && (stop_c || !csq || !thq))
      ev_d = 1'b0;
    prev_d = start_c;
    tick_d = min_tick ? 32'h0000_0000 : tick_q + 32'h0000_0001;
    rate_d = rate_q;
    if (start_selector >= ecc_pkg::SEL_RATE_MIN && rate_due)
      rate_d = 11'h000;
    else if (min_tick && rate_q != 11'h7ff)
      rate_d = rate_q + 11'h001;
    run_d = run_q;
    if (!ev_q && ev_d)
      run_d = 11'h000;
    else if (ev_q && min_tick && run_q != 11'h7ff)
      run_d = run_q + 11'h001;
  end

  // Start-blocking never uses the first cycle as a fresh edge; reset loads blocked, a start other than selector 0 must fall first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ev_q <= 1'b0;
      blk_q <= 1'b1;
      prev_q <= 1'b1;
      tick_q <= ecc_pkg::RST_ZERO;
      rate_q <= 11'h000;
      run_q <= 11'h000;
    end
    else
    begin
      ev_q <= ev_d;
      blk_q <= blk_d;
      prev_q <= prev_d;
      tick_q <= tick_d;
      rate_q <= rate_d;
      run_q <= run_d;
    end
  end

  // Outputs
  assign event_active = ev_q;
  assign status_bits = {thq, csq, ev_q ? stop_c : start_c};
  assign load_switch = (load_output_source == ecc_pkg::OUT_EVENT) && ev_q;
  assign relay_switch = (relay_output_source == ecc_pkg::OUT_EVENT) && ev_q;

  // APB slave, zero wait states
  logic [31:0] rd_d;
  logic wr;
  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  always_comb
  begin
    start_d = (wr && paddr == ecc_pkg::ADDR_START) ? pwdata : start_q;
    stop_d = (wr && paddr == ecc_pkg::ADDR_STOP) ? pwdata : stop_q;
    qual_d = (wr && paddr == ecc_pkg::ADDR_QUAL) ? pwdata : qual_q;
    setp_d = (wr && paddr == ecc_pkg::ADDR_SETP) ? pwdata : setp_q;
    case (paddr)
      ecc_pkg::ADDR_START: rd_d = start_q;
      ecc_pkg::ADDR_STOP: rd_d = stop_q;
      ecc_pkg::ADDR_QUAL: rd_d = qual_q;
      ecc_pkg::ADDR_SETP: rd_d = setp_q;
      ecc_pkg::ADDR_STATUS: rd_d = {26'h0, relay_switch, load_switch, status_bits, ev_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end
  // Unmapped addresses read zero and flag an error
  assign pslverr = psel && penable && !(paddr == ecc_pkg::ADDR_START ||
    paddr == ecc_pkg::ADDR_STOP || paddr == ecc_pkg::ADDR_QUAL ||
    paddr == ecc_pkg::ADDR_SETP || (paddr == ecc_pkg::ADDR_STATUS && !pwrite));
  assign prdata = rd_d;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_q <= ecc_pkg::RST_ZERO;
      stop_q <= ecc_pkg::RST_ZERO;
      qual_q <= ecc_pkg::RST_ZERO;
      setp_q <= ecc_pkg::RST_ZERO;
    end
    else
    begin
      start_q <= start_d;
      stop_q <= stop_d;
      qual_q <= qual_d;
      setp_q <= setp_d;
    end
  end

  // Checks
  start_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ev_q) |-> $past(start_c && csq && thq && !stop_c)) else $error("start gate");
  rise_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ev_q && !(start_c && csq && thq && !stop_c)) |=> !ev_q)
    else $error("event rose without all conditions");
  fall_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_q && (stop_c || !csq || !thq)) |=> !ev_q) else $error("event not ended");
  lbd_force_a: assert property (@(posedge pclk) disable iff (!presetn)
    (low_battery_disconnect && charge_state_qualifier < 4'h8) |-> !status_bits[1])
    else $error("disconnect override missed");
  thq_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (threshold_qualifier == 4'h0) |-> status_bits[2]) else $error("disabled qualifier low");
  load_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    (load_output_source == 4'h4) |-> (load_switch == ev_q)) else $error("load mismatch");
  block_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ev_q && blk_q && start_selector != ecc_pkg::SEL_ALWAYS) |=> !ev_q)
    else $error("retrigger");
  stop_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    (start_c && !prev_q && stop_c) |=> blk_q) else $error("stop did not block");
  first_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_bits[0] == (ev_q ? stop_c : start_c)) else $error("first bit wrong");
endmodule
`default_nettype wire

// file: pkg/ecc_pkg.sv
// Package for the conditional event controller: register map, selector codes, timing.
// Assumes a 40 MHz pclk and APB register access.
package ecc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_START = 8'h00;
  localparam logic [7:0] ADDR_STOP = 8'h04;
  localparam logic [7:0] ADDR_QUAL = 8'h08;
  localparam logic [7:0] ADDR_SETP = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // Field positions
  localparam int SEL_LSB = 0;
  localparam int SET_LSB = 8;
  localparam int CSQ_LSB = 0;
  localparam int THQ_LSB = 4;
  localparam int SNS_LSB = 8;
  localparam int LOAD_LSB = 12;
  localparam int RELAY_LSB = 16;
  localparam int ST_EVENT = 0;
  localparam int ST_FIRST = 1;
  localparam int ST_CSQ = 2;
  localparam int ST_THQ = 3;
  localparam int ST_LOAD = 4;
  localparam int ST_RELAY = 5;
  // Selector codes
  localparam logic [3:0] SEL_ALWAYS = 4'h0;
  localparam logic [3:0] SEL_RATE_MIN = 4'he;
  localparam logic [3:0] SEL_RATE_HR = 4'hf;
  localparam logic [1:0] SENSE_TERMINAL = 2'h2;
  localparam logic [3:0] OUT_EVENT = 4'h4;
  localparam logic [3:0] CSQ_NO_LBD = 4'h8;
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // Timing: one minute tick and six-minute (0.1 h) units
  localparam int CLK_HZ = 40_000_000;
  localparam int MINUTE_S = 60;
  // A minute at 40 MHz is past the int range, so the product is formed wide
  localparam logic [31:0] MINUTE_CYC = 32'(longint'(CLK_HZ) * longint'(MINUTE_S));
  localparam int TENTH_HOUR_MIN = 6;
endpackage

// file: verif/ecc_plant.sv
// Model of the measured battery system with its load and relay switches.
// Assumes the bench sets levels and flags through the two tasks below.
`timescale 1ns/1ps
`default_nettype none
module ecc_plant (
  // Clock
  input wire logic pclk,
  // Levels in setpoint units, time in tenths of an hour
  output var logic [15:0] time_of_day,
  output var logic [15:0] panel_voltage,
  output var logic [15:0] battery_voltage,
  output var logic [15:0] sense_voltage,
  output var logic [15:0] bus_voltage,
  output var logic [15:0] temperature,
  // Flags
  output var logic float_state,
  output var logic is_night,
  output var logic push_button_input,
  output var logic bus_digital_input,
  output var logic low_battery_disconnect,
  // Switched loads, only watched
  input wire logic load_switch,
  input wire logic relay_switch
);
  initial
  begin
    {time_of_day, panel_voltage, battery_voltage} = '0;
    {sense_voltage, bus_voltage, temperature} = '0;
    {low_battery_disconnect, bus_digital_input, push_button_input} = '0;
    {is_night, float_state} = '0;
  end
  // Levels change just after an edge so the block never sees a half update
  task automatic set_meas(input logic [15:0] t, b, s, u);
    @(posedge pclk);
    time_of_day <= t;
    panel_voltage <= b;
    battery_voltage <= b;
    temperature <= b;
    sense_voltage <= s;
    bus_voltage <= u;
  endtask
  task automatic set_flags(input logic [4:0] f);
    @(posedge pclk);
    {low_battery_disconnect, bus_digital_input, push_button_input, is_night, float_state} <= f;
  endtask
endmodule
`default_nettype wire

// file: verif/event_condition_controller_test.sv
// Self-checking bench for the event controller over APB.
// Assumes the plant model for all measurements and a short minute tick.
`timescale 1ns/1ps
`default_nettype none
module event_condition_controller_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [15:0] tod, pv, bv, sv, uv, tc;
  logic fl, ni, pb, dg, lb, ev, ld, rl, e;
  logic [2:0] sb;
  int errors = 0, samples_checked = 0;
  always #12.5 pclk = ~pclk;
  ecc_event_ctrl #(.MINUTE_CYCLES(32'h0000_000a)) ecc_event_ctrl_inst (.pclk(pclk),
    .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .time_of_day(tod),
    .panel_voltage(pv), .battery_voltage(bv), .sense_voltage(sv), .bus_voltage(uv),
    .temperature(tc), .float_state(fl), .is_night(ni), .push_button_input(pb),
    .bus_digital_input(dg), .low_battery_disconnect(lb), .event_active(ev),
    .status_bits(sb), .load_switch(ld), .relay_switch(rl));
  ecc_plant ecc_plant_inst (.pclk(pclk), .time_of_day(tod), .panel_voltage(pv),
    .battery_voltage(bv), .sense_voltage(sv), .bus_voltage(uv), .temperature(tc),
    .float_state(fl), .is_night(ni), .push_button_input(pb), .bus_digital_input(dg),
    .low_battery_disconnect(lb), .load_switch(ld), .relay_switch(rl));
  task results;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task check(input string n, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x)
    begin
      errors++;
      $display("BAD %s exp %h got %h", n, x, s);
    end
  endtask
  // One idle edge first, so psel is never written twice in one step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task ms(input logic [15:0] t, b, s, u);
    ecc_plant_inst.set_meas(t, b, s, u);
  endtask
  task t_reset;
    tick(1);
    check("event", ev, 1);
    apb(0, ecc_pkg::ADDR_STATUS, 0);
    check("status", rd, 32'h0000_000d);
    apb(0, 8'h14, 0);
    check("unmapped err", err, 1);
    check("unmapped data", rd, 0);
  endtask
  task t_csq;
    for (int c = 0; c < 16; c++)
    begin
      apb(1, ecc_pkg::ADDR_QUAL, 32'(c));
      for (int f = 0; f < 16; f++)
      begin
        ecc_plant_inst.set_flags({f[3], f[2], 1'b0, f[1], f[0]});
        tick(1);
        case (c % 8)
          0: e = 1;
          1: e = fl;
          2: e = ni;
          3: e = !ni;
          4: e = dg;
          5: e = fl & ni;
          6: e = fl & !ni;
          default: e = fl & dg;
        endcase
        if (c < 8 && lb)
          e = 0;
        check("charge qual", sb[1], e);
      end
    end
    ecc_plant_inst.set_flags(5'h00);
  endtask
  task t_thq;
    logic [15:0] m;
    apb(1, ecc_pkg::ADDR_SETP, 32'd100);
    for (int s = 0; s < 3; s += 2)
      for (int v = 99; v < 102; v++)
      begin
        ms(16'(v), 16'(v), 16'(v), 16'(200 - v));
        for (int q = 0; q < 9; q++)
        begin
          apb(1, ecc_pkg::ADDR_QUAL, 32'(q << 4 | s << 8));
          tick(1);
          m = (q == 5 || q == 6) ? ((s == 2) ? 16'(v) : 16'(200 - v)) : 16'(v);
          e = (q == 0) ? 1'b1 : (q % 2 == 1) ? (m > 100) : (m < 100);
          check("threshold qual", sb[2], e);
        end
      end
  endtask
  task t_event;
    apb(1, ecc_pkg::ADDR_QUAL, 32'h0004_4000);
    apb(1, ecc_pkg::ADDR_START, 32'h0000_320c);
    apb(1, ecc_pkg::ADDR_STOP, 32'h0000_5a0c);
    ms(0, 40, 0, 0);
    tick(2);
    check("idle first bit", sb[0], 0);
    ms(0, 60, 0, 0);
    tick(2);
    check("started", ev, 1);
    check("load", ld, 1);
    check("relay", rl, 1);
    check("stop bit", sb[0], 0);
    ms(0, 95, 0, 0);
    tick(2);
    check("stopped", ev, 0);
    ms(0, 60, 0, 0);
    tick(2);
    check("no retrigger", ev, 0);
    ms(0, 40, 0, 0);
    apb(1, ecc_pkg::ADDR_STOP, 32'h0000_4600);
    ms(0, 60, 0, 0);
    tick(2);
    check("restart", ev, 1);
    apb(1, ecc_pkg::ADDR_QUAL, 32'h0004_4002);
    tick(2);
    check("qual drop", ev, 0);
    apb(1, ecc_pkg::ADDR_QUAL, 32'h0004_4000);
    apb(1, ecc_pkg::ADDR_STOP, 32'h0000_460d);
    ms(0, 40, 0, 0);
    ms(0, 60, 0, 0);
    tick(2);
    check("stop priority", ev, 0);
    apb(1, ecc_pkg::ADDR_STOP, 32'h0000_4600);
    tick(2);
    check("stop edge block", ev, 0);
    apb(1, ecc_pkg::ADDR_QUAL, 32'h0004_4002);
    ms(0, 40, 0, 0);
    ms(0, 60, 0, 0);
    tick(2);
    check("qualifier wait", ev, 0);
    apb(1, ecc_pkg::ADDR_QUAL, 32'h0004_4000);
    tick(2);
    check("late start", ev, 1);
    apb(1, ecc_pkg::ADDR_QUAL, 32'h0004_4002);
  endtask
  task t_run;
    apb(1, ecc_pkg::ADDR_STOP, 32'h0000_020e);
    apb(1, ecc_pkg::ADDR_QUAL, 32'h0004_4000);
    for (int k = 0; k < 2; k++)
    begin
      ms(0, 40, 0, 0);
      tick(2);
      ms(0, 60, 0, 0);
      tick(12);
      check("running", ev, 1);
      tick(27);
      check("run over", ev, 0);
    end
  endtask
  // Starts counted over whole repeat periods, so the tick phase does not matter
  task t_rate;
    int n;
    logic p;
    apb(1, ecc_pkg::ADDR_STOP, 32'h0000_010e);
    apb(1, ecc_pkg::ADDR_START, 32'h0000_030e);
    tick(40);
    n = 0;
    p = ev;
    repeat (90)
    begin
      tick(1);
      if (ev && !p)
        n++;
      p = ev;
    end
    check("rate minutes", n, 3);
    apb(1, ecc_pkg::ADDR_START, 32'h0000_010f);
    tick(70);
    n = 0;
    p = ev;
    repeat (120)
    begin
      tick(1);
      if (ev && !p)
        n++;
      p = ev;
    end
    check("rate hours", n, 2);
  endtask
  task t_wrap;
    apb(1, ecc_pkg::ADDR_START, 32'h0000_dc01);
    apb(1, ecc_pkg::ADDR_STOP, 32'h0000_1401);
    ms(100, 0, 0, 0);
    ms(230, 0, 0, 0);
    tick(2);
    check("late start", ev, 1);
    ms(10, 0, 0, 0);
    tick(2);
    check("past midnight", ev, 1);
    ms(30, 0, 0, 0);
    tick(2);
    check("next day stop", ev, 0);
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    check("reset event", ev, 0);
    presetn <= 1;
    t_reset;
    t_csq;
    t_thq;
    t_event;
    t_run;
    t_wrap;
    t_rate;
    results;
  end
  // Whole run needs about 1300 cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    results;
  end
endmodule
`default_nettype wire
